// ===== logic/mar_reducer.sv
// matrix axis reducer: collapses a raster-order matrix stream to one row or column
// assumes producer and consumer run on the same clock with valid/ready handshakes
//
// Operation
// - axis 0: fold all rows together, emit one value per column
// - axis 1: fold all columns together, emit one value per row
// - sum: each output is the total along the reduced axis
// - average: each output is the mean along the reduced axis
// - maximum: each output is the largest value along the axis
// - minimum: each output is the smallest value along the axis
// - every input consumed exactly once; whole output vector emitted
`default_nettype none
module mar_reducer (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic axis_select,
  input wire logic [2:0] reduction_operation_select,
  output logic busy,
  // input pixel stream, raster order
  input wire logic in_valid,
  input wire logic [mar_pkg::PIX_W-1:0] in_data,
  output logic in_ready,
  // output vector stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [mar_pkg::ACC_W-1:0] out_data,
  output logic out_last
);
  // same time base as the bench modules; the logic itself holds no delays
  timeunit 1ns;
  timeprecision 1ps;
  import mar_pkg::*;

  mar_state_e state;
  mar_state_e next_state;
  logic dim;
  logic [2:0] op;
  logic [IDX_W-1:0] row;
  logic [IDX_W-1:0] col;
  mar_accumulator_type_t acc [MAXN];
  logic [CNT_W-1:0] out_idx;
  logic in_fire;
  logic out_fire;
  logic last_pix;
  logic first;
  logic [IDX_W-1:0] acc_idx;
  logic [CNT_W-1:0] n_out;
  logic load_out;
  mar_accumulator_type_t in_ext;
  mar_accumulator_type_t comb_out;
  mar_accumulator_type_t acc_rd;
  mar_accumulator_type_t divisor;
  mar_accumulator_type_t div_res;

  // handshakes and position decode
  assign in_fire = in_valid && in_ready;
  assign out_fire = out_valid && out_ready;
  assign last_pix = (row == LAST_ROW) && (col == LAST_COL);
  assign in_ext = {{(ACC_W-PIX_W){1'b0}}, in_data};
  assign acc_idx = (dim == AXIS_TO_COL) ? row : col;
  assign first = (dim == AXIS_TO_COL) ? (col == '0) : (row == '0);
  assign n_out = (dim == AXIS_TO_COL) ? ROWS_N : COLS_N;
  assign load_out = (state == ST_EMIT) && (!out_valid || out_ready) && (out_idx != n_out);

  // sequencing: idle, take the matrix, then emit the vector
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = ST_LOAD;
      ST_LOAD: if (in_fire && last_pix) next_state = ST_EMIT;
      ST_EMIT: if (out_fire && out_last) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // settings latched at start so a change mid-run cannot mix two modes
  always_ff @(posedge clock) begin
    if (reset) begin
      dim <= AXIS_TO_ROW;
      op <= OP_SUM;
    end else if (state == ST_IDLE && start) begin
      dim <= axis_select;
      op <= (reduction_operation_select > OP_MIN) ? OP_SUM : reduction_operation_select;
    end
  end

  // raster position of the next pixel
  always_ff @(posedge clock) begin
    if (reset) begin
      row <= '0;
      col <= '0;
    end else if (state == ST_IDLE && start) begin
      row <= '0;
      col <= '0;
    end else if (in_fire) begin
      col <= (col == LAST_COL) ? '0 : col + 2'h1;
      if (col == LAST_COL) begin
        row <= row + 2'h1;
      end
    end
  end

  // ready only while loading; drops right after the last pixel is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      in_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      in_ready <= (next_state == ST_LOAD);
      busy <= (next_state != ST_IDLE);
    end
  end

  mar_combine u_combine (
    .op(op),
    .first(first),
    .acc_in(acc[acc_idx]),
    .pix(in_ext),
    .acc_out(comb_out)
  );

  // one accumulator per output element, written as its pixels arrive
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < MAXN; i++) begin
        acc[i] <= '0;
      end
    end else if (in_fire) begin
      acc[acc_idx] <= comb_out;
    end
  end

  // divisor is the length of the reduced axis; constant divide keeps it small
  assign acc_rd = acc[out_idx[IDX_W-1:0]];
  assign divisor = (dim == AXIS_TO_COL) ? COLS_ACC : ROWS_ACC;
  assign div_res = (op == OP_AVERAGE) ? acc_rd / divisor : acc_rd;

  // output register stage; a full cycle after the last write avoids a bypass
  always_ff @(posedge clock) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_last <= 1'b0;
      out_idx <= '0;
    end else if (state == ST_IDLE && start) begin
      out_idx <= '0;
    end else if (load_out) begin
      out_valid <= 1'b1;
      out_data <= div_res;
      out_last <= (out_idx == n_out - 3'h1);
      out_idx <= out_idx + 3'h1;
    end else if (out_fire) begin
      out_valid <= 1'b0;
      out_last <= 1'b0;
    end
  end

  // helper counters read only by the checks below
  logic [TOT_W-1:0] in_cnt;
  logic [CNT_W-1:0] out_cnt;
  logic [IDX_W-1:0] shown_idx;
  mar_accumulator_type_t scaled;
  assign shown_idx = out_idx[IDX_W-1:0] - 2'h1;
  assign scaled = out_data * divisor;

  always_ff @(posedge clock) begin
    if (reset || (state == ST_IDLE && start)) begin
      in_cnt <= '0;
      out_cnt <= '0;
    end else begin
      if (in_fire) in_cnt <= in_cnt + 5'h01;
      if (out_fire) out_cnt <= out_cnt + 3'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_load_done;
    state == ST_LOAD ##1 state == ST_EMIT;
  endsequence

  sequence s_last_out;
    out_fire && out_last;
  endsequence

  a_row_length: assert property (
    out_fire && out_last && dim == AXIS_TO_ROW |-> out_cnt == COLS_N - 3'h1)
    else $error("row result length wrong");
  a_col_length: assert property (
    out_fire && out_last && dim == AXIS_TO_COL |-> out_cnt == ROWS_N - 3'h1)
    else $error("column result length wrong");
  a_sum_update: assert property (
    in_fire && !first && op == OP_SUM
    |=> acc[$past(acc_idx)] == $past(acc[acc_idx]) + $past(in_ext))
    else $error("sum accumulation wrong");
  a_avg_output: assert property (
    out_valid && op == OP_AVERAGE
    |-> scaled <= acc[shown_idx] && (acc[shown_idx] - scaled) < divisor)
    else $error("average result wrong");
  a_max_update: assert property (
    in_fire && !first && op == OP_MAX
    |=> acc[$past(acc_idx)] >= $past(in_ext) && acc[$past(acc_idx)] >= $past(acc[acc_idx]))
    else $error("maximum accumulation wrong");
  a_min_update: assert property (
    in_fire && !first && op == OP_MIN
    |=> acc[$past(acc_idx)] <= $past(in_ext) && acc[$past(acc_idx)] <= $past(acc[acc_idx]))
    else $error("minimum accumulation wrong");
  a_all_consumed: assert property (
    s_load_done |-> in_cnt == PIX_TOTAL && !in_ready)
    else $error("input count wrong at end of load");
  a_emit_finish: assert property (
    s_last_out |=> state == ST_IDLE && !busy && !out_valid)
    else $error("did not finish after last output");
  a_acc_no_wrap: assert property (
    in_fire && !first && (op == OP_SUM || op == OP_AVERAGE)
    |=> acc[$past(acc_idx)] >= $past(acc[acc_idx]))
    else $error("accumulator wrapped");
  a_default_sum: assert property (
    state == ST_IDLE && start && reduction_operation_select > OP_MIN |=> op == OP_SUM)
    else $error("unknown operation not mapped to sum");
endmodule
`default_nettype wire

// ===== common/mar_pkg.sv
// package for the matrix axis reducer: sizes, operation codes, states
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
package mar_pkg;
  // matrix geometry and data widths
  localparam int ROWS = 4;
  localparam int COLS = 4;
  localparam int PIX_W = 8;
  // accumulator is wide enough for COLS or ROWS full-scale pixels summed
  localparam int ACC_W = 16;
  localparam int MAXN = 4;
  localparam int IDX_W = 2;
  localparam int CNT_W = 3;
  localparam int TOT_W = 5;
  // typed copies for compares and arithmetic at the target width
  localparam logic [IDX_W-1:0] LAST_ROW = 2'h3;
  localparam logic [IDX_W-1:0] LAST_COL = 2'h3;
  localparam logic [CNT_W-1:0] ROWS_N = 3'h4;
  localparam logic [CNT_W-1:0] COLS_N = 3'h4;
  localparam logic [ACC_W-1:0] ROWS_ACC = 16'h0004;
  localparam logic [ACC_W-1:0] COLS_ACC = 16'h0004;
  localparam logic [TOT_W-1:0] PIX_TOTAL = 5'h10;
  // axis selector values
  localparam logic AXIS_TO_ROW = 1'h0;
  localparam logic AXIS_TO_COL = 1'h1;
  // reduction operation codes; any other code falls back to sum
  localparam logic [2:0] OP_SUM = 3'h0;
  localparam logic [2:0] OP_AVERAGE = 3'h1;
  localparam logic [2:0] OP_MAX = 3'h2;
  localparam logic [2:0] OP_MIN = 3'h3;
  typedef logic [ACC_W-1:0] mar_accumulator_type_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_EMIT} mar_state_e;
endpackage
`default_nettype wire

// ===== logic/mar_combine.sv
// one combine step of the reducer: folds a pixel into a running value
// assumes the caller flags the first element along the reduced axis
`default_nettype none
module mar_combine (
  // operation and position
  input wire logic [2:0] op,
  input wire logic first,
  // operands and result
  input wire logic [mar_pkg::ACC_W-1:0] acc_in,
  input wire logic [mar_pkg::ACC_W-1:0] pix,
  output logic [mar_pkg::ACC_W-1:0] acc_out
);
  // same time base as the bench modules; the logic itself holds no delays
  timeunit 1ns;
  timeprecision 1ps;
  import mar_pkg::*;

  // the first element seeds the value, so no identity constant is needed
  always_comb begin
    acc_out = acc_in + pix;
    if (first) begin
      acc_out = pix;
    end else begin
      unique case (op)
        OP_SUM, OP_AVERAGE: acc_out = acc_in + pix;
        OP_MAX: acc_out = (pix > acc_in) ? pix : acc_in;
        OP_MIN: acc_out = (pix < acc_in) ? pix : acc_in;
        default: acc_out = acc_in + pix;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verification/mar_partner.sv
// stream partner: pixel producer and result consumer around the reducer
// assumes the bench fills pix_q before start and reads res_q after busy falls
`default_nettype none
module mar_partner (
  // clock
  input wire logic clock,
  // producer side
  input wire logic in_ready,
  output logic in_valid,
  output logic [mar_pkg::PIX_W-1:0] in_data,
  // consumer side
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [mar_pkg::ACC_W-1:0] out_data,
  input wire logic out_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [mar_pkg::PIX_W-1:0] pix_q[$];
  logic [mar_pkg::ACC_W:0] res_q[$];
  int stall_pct = 0;
  int seed = 96;
  bit took;
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b0;
  end
  // a pixel is held until taken; an idle bus inverts its data on every idle cycle
  always @(posedge clock) begin
    took = in_valid && in_ready;
    if (out_valid && out_ready) res_q.push_back({out_last, out_data});
    if (took) void'(pix_q.pop_front());
    #1;
    if (!in_valid || took) begin
      if (pix_q.size() > 0 && {$random(seed)} % 100 >= stall_pct) begin
        in_valid = 1'b1;
        in_data = pix_q[0];
      end else begin
        in_valid = 1'b0;
        in_data = ~in_data;
      end
    end
    out_ready = ({$random(seed)} % 100 >= stall_pct);
  end
endmodule
`default_nettype wire

// ===== verification/mar_reducer_bench.sv
// bench for the matrix axis reducer: every axis and operation, random matrices
// assumes mar_partner feeds pixels and collects results on the same clock
`default_nettype none
module mar_reducer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mar_pkg::*;
  logic clock, reset, start, axis_select, busy, in_valid, in_ready;
  logic out_valid, out_ready, out_last;
  logic [2:0] reduction_operation_select;
  logic [PIX_W-1:0] in_data;
  logic [ACC_W-1:0] out_data;
  int fails = 0;
  int n_tests = 0;
  int seed = 96;
  int a, o;
  mar_reducer dut (.clock(clock), .reset(reset), .start(start), .axis_select(axis_select),
    .reduction_operation_select(reduction_operation_select), .busy(busy),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
  mar_partner u_partner (.clock(clock), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_last(out_last));
  // free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [ACC_W:0] seen, input logic [ACC_W:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one operation: integer model first, then drive, then compare every element
  task automatic run(input int axis, input int op, input int full, input int stall, input bit poke);
    int m[16];
    int e[4];
    int v, k, n;
    u_partner.stall_pct = stall;
    u_partner.res_q.delete();
    for (k = 0; k < 16; k++) begin
      m[k] = full ? 255 : ({$random(seed)} % 256);
      u_partner.pix_q.push_back(m[k][7:0]);
    end
    for (k = 0; k < 4; k++) begin
      for (n = 0; n < 4; n++) begin
        v = axis ? m[k * 4 + n] : m[n * 4 + k];
        if (n == 0) e[k] = v;
        else if (op == 2) e[k] = (v > e[k]) ? v : e[k];
        else if (op == 3) e[k] = (v < e[k]) ? v : e[k];
        else e[k] += v;
      end
      if (op == 1) e[k] = e[k] / 4;
    end
    @(posedge clock);
    #1;
    start = 1'b1;
    axis_select = axis[0];
    reduction_operation_select = op[2:0];
    @(posedge clock);
    #1;
    // a second start while busy must change nothing, nor may the new selectors
    start = poke;
    axis_select = ~axis[0];
    reduction_operation_select = ~op[2:0];
    @(posedge clock);
    #1;
    start = 1'b0;
    check({16'h0000, busy}, 17'h00001, "busy after start");
    for (k = 0; k < 400 && busy !== 1'b0; k++) begin
      @(posedge clock);
      #1;
    end
    check({16'h0000, busy}, 17'h00000, "busy never fell");
    check(17'(u_partner.pix_q.size()), 17'h00000, "pixels left");
    check(17'(u_partner.res_q.size()), 17'h00004, "result count");
    for (k = 0; k < 4; k++) begin
      check(u_partner.res_q[k], {k == 3, e[k][15:0]}, "element");
    end
    $display("test axis %0d op %0d stall %0d done", axis, op, stall);
  endtask
  // watchdog: about 20 operations of under 200 cycles each
  initial begin
    #100000;
    fails++;
    summarize;
  end
  initial begin
    reset = 1'b1;
    start = 1'b0;
    axis_select = 1'b0;
    reduction_operation_select = 3'h0;
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    check({14'h0000, busy, in_ready, out_valid}, 17'h00000, "reset state");
    check({out_last, out_data}, 17'h00000, "reset result");
    run(0, 0, 1, 0, 0);
    run(1, 1, 1, 50, 1);
    for (a = 0; a < 2; a++) begin
      for (o = 0; o < 8; o++) begin
        run(a, o, 0, (o % 2) * 40, o == 5);
      end
    end
    summarize;
  end
endmodule
`default_nettype wire
